// ### design/escs_pkg.sv
// constants and types for the erase-suspend flash command sequencer (host side)
// assumes a word-mode parallel NOR flash wired to the controller pins, 50 MHz MCLK
package escs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CLEAR = 8'h14;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_ERASING = 2;
    localparam int ST_SUSP = 3;
    // operation codes written to the command register
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_PROG = 4'h1;
    localparam logic [3:0] OP_SERASE = 4'h2;
    localparam logic [3:0] OP_CERASE = 4'h3;
    localparam logic [3:0] OP_SUSPEND = 4'h4;
    localparam logic [3:0] OP_RESUME = 4'h5;
    localparam logic [3:0] OP_PROTVFY = 4'h6;
    localparam logic [3:0] OP_SECENTER = 4'h7;
    localparam logic [3:0] OP_RESET = 4'h8;
    localparam logic [3:0] OP_BYPENTER = 4'h9;
    localparam logic [3:0] OP_BYPPROG = 4'hA;
    localparam logic [3:0] OP_LOCKID = 4'hB;
    // command cycle values
    localparam logic [19:0] A_555 = 20'h00555;
    localparam logic [19:0] A_2AA = 20'h002AA;
    localparam logic [15:0] D_AA = 16'h00AA;
    localparam logic [15:0] D_55 = 16'h0055;
    localparam logic [15:0] D_90 = 16'h0090;
    localparam logic [15:0] D_88 = 16'h0088;
    localparam logic [15:0] D_A0 = 16'h00A0;
    localparam logic [15:0] D_80 = 16'h0080;
    localparam logic [15:0] D_10 = 16'h0010;
    localparam logic [15:0] D_30 = 16'h0030;
    localparam logic [15:0] D_B0 = 16'h00B0;
    localparam logic [15:0] D_F0 = 16'h00F0;
    localparam logic [11:0] OFS_PROT = 12'h002;
    localparam logic [11:0] OFS_LOCK = 12'h003;
    localparam int SECT_LSB = 12;
    // bus cycle timing
    localparam int CLK_NS = 20;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 25;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_STROBE = 4'b0100,
        CY_HOLD = 4'b1000
    } escs_cyc_state_t;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_ISSUE = 3'b010,
        SQ_WAIT = 3'b100
    } escs_seq_state_t;
endpackage

// ### design/escs_cycle.sv
// one flash bus cycle: a command/program write or an array read
// assumes the flash inputs are synchronous to MCLK
`timescale 1ns/1ps
`default_nettype none
module escs_cycle #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic wr,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic done,
    output logic [DW-1:0] rdata,
    output logic [AW-1:0] f_addr,
    output logic [DW-1:0] f_dq_o,
    output logic f_dq_oe,
    input wire logic [DW-1:0] f_dq_i,
    output logic f_ce_n,
    output logic f_we_n,
    output logic f_oe_n
);
    escs_pkg::escs_cyc_state_t st_q;
    logic wr_q;
    logic [3:0] cnt_q;
    logic last_tick;

    initial begin
        if (AW < 13 || DW < 8) begin
            $error("escs_cycle: address or data too narrow");
        end
    end

    assign last_tick = (cnt_q == 4'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= escs_pkg::CY_IDLE;
            wr_q <= 1'b0;
            cnt_q <= 4'h0;
            done <= 1'b0;
            rdata <= '0;
            f_addr <= '0;
            f_dq_o <= '0;
            f_dq_oe <= 1'b0;
            f_ce_n <= 1'b1;
            f_we_n <= 1'b1;
            f_oe_n <= 1'b1;
        end else if (ce) begin
            done <= 1'b0;
            case (st_q)
                escs_pkg::CY_IDLE: begin
                    if (start) begin
                        st_q <= escs_pkg::CY_SETUP;
                        wr_q <= wr;
                        f_addr <= addr;
                        f_dq_o <= wdata;
                        f_dq_oe <= wr;
                        f_ce_n <= 1'b0;
                    end
                end
                escs_pkg::CY_SETUP: begin
                    st_q <= escs_pkg::CY_STROBE;
                    f_we_n <= ~wr_q;
                    f_oe_n <= wr_q;
                    cnt_q <= wr_q ? 4'(escs_pkg::WP_CYC - 1) : 4'(escs_pkg::ACC_CYC - 1);
                end
                escs_pkg::CY_STROBE: begin
                    if (last_tick) begin
                        st_q <= escs_pkg::CY_HOLD;
                        f_we_n <= 1'b1;
                        f_oe_n <= 1'b1;
                        cnt_q <= 4'(escs_pkg::WPH_CYC - 1);
                        if (!wr_q) begin
                            rdata <= f_dq_i;
                        end
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                escs_pkg::CY_HOLD: begin
                    f_dq_oe <= 1'b0;
                    f_ce_n <= 1'b1;
                    if (last_tick) begin
                        st_q <= escs_pkg::CY_IDLE;
                        done <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: st_q <= escs_pkg::CY_IDLE;
            endcase
        end
    end

    chk_we_only_write: assert property (@(posedge clk) disable iff (!rst_n)
        !f_we_n |-> f_dq_oe && !f_ce_n && f_oe_n)
        else $error("write strobe without driven data");
endmodule
`default_nettype wire

// ### design/escs_top.sv
// host controller that sequences flash commands, incl. erase suspend and resume
// assumes an AXI4-Lite master on the register side and one word-mode flash on the pins
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module escs_top #(
    parameter int AW = 20
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic [AW-1:0] F_ADDR,
    output logic [15:0] F_DQ_O,
    output logic F_DQ_OE,
    input wire logic [15:0] F_DQ_I,
    output logic F_CE_N,
    output logic F_WE_N,
    output logic F_OE_N
);
    initial begin
        if (AW != 20) begin
            $error("escs_top: command addresses assume a 20-bit word address");
        end
    end

    // ************************************************************
    // step table
    // ************************************************************
    // fields: last, write, address, data
    function automatic logic [37:0] step_f(input logic [3:0] op, input logic [2:0] i,
                                           input logic [19:0] a, input logic [15:0] d);
        logic [37:0] s;
        s = {1'b1, 1'b0, a, 16'h0000};
        if (i == 3'd0 && op != escs_pkg::OP_READ && op != escs_pkg::OP_SUSPEND &&
            op != escs_pkg::OP_RESUME && op != escs_pkg::OP_RESET &&
            op != escs_pkg::OP_BYPPROG) begin
            s = {1'b0, 1'b1, escs_pkg::A_555, escs_pkg::D_AA};
        end else if (i == 3'd1 && op != escs_pkg::OP_BYPPROG) begin
            s = {1'b0, 1'b1, escs_pkg::A_2AA, escs_pkg::D_55};
        end else begin
            case (op)
                escs_pkg::OP_READ: s = {1'b1, 1'b0, a, 16'h0000};
                escs_pkg::OP_SUSPEND: s = {1'b1, 1'b1, 20'h00000, escs_pkg::D_B0};
                escs_pkg::OP_RESUME: s = {1'b1, 1'b1, 20'h00000, escs_pkg::D_30};
                escs_pkg::OP_RESET: s = {1'b1, 1'b1, 20'h00000, escs_pkg::D_F0};
                escs_pkg::OP_BYPPROG: s = (i == 3'd0) ? {1'b0, 1'b1, 20'h00000, escs_pkg::D_A0}
                                                      : {1'b1, 1'b1, a, d};
                escs_pkg::OP_PROG: s = (i == 3'd2) ? {1'b0, 1'b1, escs_pkg::A_555, escs_pkg::D_A0}
                                                   : {1'b1, 1'b1, a, d};
                escs_pkg::OP_PROTVFY: s = (i == 3'd2) ? {1'b0, 1'b1, escs_pkg::A_555, escs_pkg::D_90}
                    : {1'b1, 1'b0, a[19:escs_pkg::SECT_LSB], escs_pkg::OFS_PROT, 16'h0000};
                escs_pkg::OP_LOCKID: s = (i == 3'd2) ? {1'b0, 1'b1, escs_pkg::A_555, escs_pkg::D_90}
                    : {1'b1, 1'b0, 8'h00, escs_pkg::OFS_LOCK, 16'h0000};
                escs_pkg::OP_SECENTER: s = {1'b1, 1'b1, escs_pkg::A_555, escs_pkg::D_88};
                escs_pkg::OP_BYPENTER: s = {1'b1, 1'b1, escs_pkg::A_555, 16'h0020};
                default: begin
                    if (i == 3'd2) begin
                        s = {1'b0, 1'b1, escs_pkg::A_555, escs_pkg::D_80};
                    end else if (i == 3'd3) begin
                        s = {1'b0, 1'b1, escs_pkg::A_555, escs_pkg::D_AA};
                    end else if (i == 3'd4) begin
                        s = {1'b0, 1'b1, escs_pkg::A_2AA, escs_pkg::D_55};
                    end else if (op == escs_pkg::OP_SERASE) begin
                        s = {1'b1, 1'b1, a[19:escs_pkg::SECT_LSB], 12'h000, escs_pkg::D_30};
                    end else begin
                        s = {1'b1, 1'b1, escs_pkg::A_555, escs_pkg::D_10};
                    end
                end
            endcase
        end
        return s;
    endfunction

    function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_take, w_take, wr_fire, ar_take;
    logic aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
    logic wr_cmd, wr_addr, wr_wdata, wr_status, wr_clear, wr_hit, rd_hit;
    logic [31:0] rd_word;

    assign aw_take = AWVALID && AWREADY;
    assign w_take = WVALID && WREADY;
    assign wr_fire = aw_hold_q && w_hold_q && !BVALID;
    assign aw_hold_d = (aw_hold_q || aw_take) && !wr_fire;
    assign w_hold_d = (w_hold_q || w_take) && !wr_fire;
    assign bvalid_d = wr_fire || (BVALID && !BREADY);
    assign ar_take = ARVALID && ARREADY;
    assign rvalid_d = ar_take || (RVALID && !RREADY);
    assign wr_cmd = wr_fire && awaddr_q[7:2] == escs_pkg::REG_CMD[7:2] && wstrb_q[0];
    assign wr_addr = wr_fire && awaddr_q[7:2] == escs_pkg::REG_ADDR[7:2];
    assign wr_wdata = wr_fire && awaddr_q[7:2] == escs_pkg::REG_WDATA[7:2];
    assign wr_status = wr_fire && awaddr_q[7:2] == escs_pkg::REG_STATUS[7:2] && wstrb_q[0];
    assign wr_clear = wr_fire && awaddr_q[7:2] == escs_pkg::REG_CLEAR[7:2] && wstrb_q[0];
    assign wr_hit = awaddr_q[7:2] <= escs_pkg::REG_CLEAR[7:2] &&
                    awaddr_q[7:2] != escs_pkg::REG_RDATA[7:2];
    assign rd_hit = ARADDR[7:2] <= escs_pkg::REG_STATUS[7:2];

    // ************************************************************
    // sequencer state and tracking
    // ************************************************************
    escs_pkg::escs_seq_state_t sq_q;
    logic [3:0] op_q;
    logic [2:0] idx_q;
    logic [19:0] addr_q;
    logic [15:0] wd_q, rd_q;
    logic refused_q, erasing_q, susp_q;
    logic [7:0] esect_q;
    logic eng_start_q, eng_done;
    logic [37:0] stp;
    logic [15:0] eng_rdata;
    logic [3:0] new_op;
    logic in_esect, op_ok, accept;
    logic [31:0] status_w;

    assign stp = step_f(op_q, idx_q, addr_q, wd_q);
    assign new_op = wdata_q[3:0];
    assign in_esect = susp_q && addr_q[19:escs_pkg::SECT_LSB] == esect_q;
    // refusals keep reads, programs and bypass programs away from erase-suspended sectors and stop stray resumes
    assign op_ok = (new_op == escs_pkg::OP_SUSPEND) ? (erasing_q && !susp_q) :
                   (new_op == escs_pkg::OP_RESUME) ? susp_q :
                   (new_op == escs_pkg::OP_READ || new_op == escs_pkg::OP_PROG ||
                    new_op == escs_pkg::OP_BYPPROG) ? !in_esect :
                   (new_op <= escs_pkg::OP_LOCKID);
    assign accept = wr_cmd && sq_q == escs_pkg::SQ_IDLE && op_ok;
    assign status_w = {28'h0000000, susp_q, erasing_q, refused_q, sq_q != escs_pkg::SQ_IDLE};
    assign rd_word = (ARADDR[7:2] == escs_pkg::REG_CMD[7:2]) ? {28'h0000000, op_q} :
                     (ARADDR[7:2] == escs_pkg::REG_ADDR[7:2]) ? {12'h000, addr_q} :
                     (ARADDR[7:2] == escs_pkg::REG_WDATA[7:2]) ? {16'h0000, wd_q} :
                     (ARADDR[7:2] == escs_pkg::REG_RDATA[7:2]) ? {16'h0000, rd_q} :
                     (ARADDR[7:2] == escs_pkg::REG_STATUS[7:2]) ? status_w : 32'h00000000;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= 2'h0;
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RRESP <= 2'h0;
            RDATA <= 32'h00000000;
        end else if (CLK_EN) begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            AWREADY <= !aw_hold_d && !bvalid_d;
            WREADY <= !w_hold_d && !bvalid_d;
            BVALID <= bvalid_d;
            ARREADY <= !rvalid_d;
            RVALID <= rvalid_d;
            if (aw_take) begin
                awaddr_q <= AWADDR;
            end
            if (w_take) begin
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (wr_fire) begin
                BRESP <= wr_hit ? 2'h0 : 2'h2;
            end
            if (ar_take) begin
                RDATA <= rd_word;
                RRESP <= rd_hit ? 2'h0 : 2'h2;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sq_q <= escs_pkg::SQ_IDLE;
            op_q <= 4'h0;
            idx_q <= 3'd0;
            addr_q <= 20'h00000;
            wd_q <= 16'h0000;
            rd_q <= 16'h0000;
            refused_q <= 1'b0;
            erasing_q <= 1'b0;
            susp_q <= 1'b0;
            esect_q <= 8'h00;
            eng_start_q <= 1'b0;
        end else if (CLK_EN) begin
            eng_start_q <= 1'b0;
            if (wr_addr) begin
                addr_q <= 20'(merge_f({12'h000, addr_q}, wdata_q, wstrb_q));
            end
            if (wr_wdata) begin
                wd_q <= 16'(merge_f({16'h0000, wd_q}, wdata_q, wstrb_q));
            end
            // a new refusal wins over a clear in the same cycle
            if (wr_cmd && !accept) begin
                refused_q <= 1'b1;
            end else if (wr_status && wdata_q[escs_pkg::ST_REFUSED]) begin
                refused_q <= 1'b0;
            end
            if (wr_clear && wdata_q[0]) begin
                erasing_q <= 1'b0;
                susp_q <= 1'b0;
            end
            case (sq_q)
                escs_pkg::SQ_IDLE: begin
                    if (accept) begin
                        op_q <= new_op;
                        idx_q <= 3'd0;
                        sq_q <= escs_pkg::SQ_ISSUE;
                    end
                end
                escs_pkg::SQ_ISSUE: begin
                    eng_start_q <= 1'b1;
                    sq_q <= escs_pkg::SQ_WAIT;
                end
                escs_pkg::SQ_WAIT: begin
                    if (eng_done) begin
                        if (!stp[36]) begin
                            rd_q <= eng_rdata;
                        end
                        if (stp[37]) begin
                            sq_q <= escs_pkg::SQ_IDLE;
                            if (op_q == escs_pkg::OP_SERASE) begin
                                erasing_q <= 1'b1;
                                esect_q <= addr_q[19:escs_pkg::SECT_LSB];
                            end
                            if (op_q == escs_pkg::OP_SUSPEND) begin
                                susp_q <= 1'b1;
                            end
                            if (op_q == escs_pkg::OP_RESUME) begin
                                susp_q <= 1'b0;
                            end
                        end else begin
                            idx_q <= idx_q + 3'd1;
                            sq_q <= escs_pkg::SQ_ISSUE;
                        end
                    end
                end
                default: sq_q <= escs_pkg::SQ_IDLE;
            endcase
        end
    end

    // ************************************************************
    // flash bus cycle engine
    // ************************************************************
    escs_cycle #(.AW(AW), .DW(16)) u_cycle (
        .clk(MCLK),
        .rst_n(RST_N),
        .ce(CLK_EN),
        .start(eng_start_q),
        .wr(stp[36]),
        .addr(stp[35:16]),
        .wdata(stp[15:0]),
        .done(eng_done),
        .rdata(eng_rdata),
        .f_addr(F_ADDR),
        .f_dq_o(F_DQ_O),
        .f_dq_oe(F_DQ_OE),
        .f_dq_i(F_DQ_I),
        .f_ce_n(F_CE_N),
        .f_we_n(F_WE_N),
        .f_oe_n(F_OE_N)
    );

    // ************************************************************
    // checks
    // ************************************************************
    chk_no_esect_access: assert property (@(posedge MCLK) disable iff (!RST_N)
        accept && (new_op == escs_pkg::OP_PROG || new_op == escs_pkg::OP_READ)
        |-> !(susp_q && addr_q[19:escs_pkg::SECT_LSB] == esect_q))
        else $error("access to erase-suspended sector accepted");
    chk_resume_cycle: assert property (@(posedge MCLK) disable iff (!RST_N)
        eng_start_q && op_q == escs_pkg::OP_RESUME
        |-> susp_q && stp[36] && stp[15:0] == 16'h0030)
        else $error("resume cycle wrong or issued while not suspended");
    chk_protect_read: assert property (@(posedge MCLK) disable iff (!RST_N)
        eng_start_q && op_q == escs_pkg::OP_PROTVFY && idx_q == 3'd3
        |-> !stp[36] && stp[27:16] == 12'h002 && stp[35:28] == addr_q[19:12])
        else $error("protect verify read at wrong address");
    chk_secure_entry: assert property (@(posedge MCLK) disable iff (!RST_N)
        eng_start_q && op_q == escs_pkg::OP_SECENTER && idx_q == 3'd2
        |-> stp[37] && stp[35:16] == 20'h00555 && stp[15:0] == 16'h0088)
        else $error("secured entry third cycle wrong");
    chk_bypass_two: assert property (@(posedge MCLK) disable iff (!RST_N)
        eng_start_q && op_q == escs_pkg::OP_BYPPROG
        |-> (idx_q == 3'd0 && stp[15:0] == 16'h00A0 && !stp[37]) ||
            (idx_q == 3'd1 && stp[37] && stp[35:16] == addr_q))
        else $error("bypass program not two cycles");
endmodule
`default_nettype wire

// ### verif/escs_flash_model.sv
// behavioural word-mode flash: unlock decode, sector erase, suspend, resume, id reads
// assumes pins sampled on the controller clock and one controller driving them
`timescale 1ns/1ps
`default_nettype none
module escs_flash_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [19:0] a,
    input wire logic [15:0] d,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    output logic [15:0] dq_i,
    output logic suspended
);
    // ****************************************
    // command decode and read mux
    // ****************************************
    logic we_q, ers_q, id_q, set_q, sus_q, prg_q;
    logic [1:0] unl_q;
    logic [7:0] sect_q;
    logic [15:0] last_q, rd;
    wire rd_on = !ce_n && !oe_n;
    assign suspended = sus_q;
    assign rd = id_q ? (a[11:0] == 12'h003 ? 16'h0089 : {15'h0000, a[11:0] == 12'h002})
              : (sus_q && a[19:12] == sect_q) ? 16'h0080 : a[15:0] ^ 16'h5A5A;
    assign dq_i = rd_on ? rd : ~last_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ers_q, id_q, set_q, sus_q, prg_q, unl_q, sect_q, last_q} <= '0;
            // idle level of the write strobe, so no false edge follows reset
            we_q <= 1'b1;
        end else begin
            we_q <= we_n;
            if (rd_on) last_q <= rd;
            if (we_n && !we_q) begin
                unl_q <= 2'h0;
                if (prg_q) prg_q <= 1'b0;
                else if (d == 16'h00AA && a[10:0] == 11'h555) unl_q <= 2'h1;
                else if (unl_q == 2'h1 && d == 16'h0055 && a[10:0] == 11'h2AA) unl_q <= 2'h2;
                else if (unl_q == 2'h2 && d == 16'h0090) id_q <= 1'b1;
                else if (unl_q == 2'h2 && d == 16'h00A0) prg_q <= 1'b1;
                else if (unl_q == 2'h2 && d == 16'h0080) set_q <= 1'b1;
                else if (unl_q == 2'h2 && set_q && d == 16'h0030) begin
                    {ers_q, set_q, sect_q} <= {2'b10, a[19:12]};
                end
                else if (d == 16'h00B0 && ers_q) sus_q <= 1'b1;
                else if (d == 16'h0030 && sus_q) sus_q <= 1'b0;
                else if (d == 16'h00F0) {id_q, set_q} <= 2'b00;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench: AXI4-Lite master driving the controller, flash model on the pins
// assumes the controller answers within the bounded waits below
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic MCLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID;
    logic ARREADY, RVALID, F_DQ_OE, F_CE_N, F_WE_N, F_OE_N, susp;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, rv;
    logic [1:0] BRESP, RRESP, rsp;
    logic [19:0] F_ADDR;
    logic [15:0] F_DQ_O, F_DQ_I;
    int failures, samples_checked;
    escs_top escs_top_inst (.MCLK(MCLK), .RST_N(RST_N), .CLK_EN(1'b1), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .F_ADDR(F_ADDR), .F_DQ_O(F_DQ_O), .F_DQ_OE(F_DQ_OE), .F_DQ_I(F_DQ_I),
        .F_CE_N(F_CE_N), .F_WE_N(F_WE_N), .F_OE_N(F_OE_N));
    escs_flash_model escs_flash_model_inst (.clk(MCLK), .rst_n(RST_N), .a(F_ADDR), .d(F_DQ_O),
        .ce_n(F_CE_N), .we_n(F_WE_N), .oe_n(F_OE_N), .dq_i(F_DQ_I), .suspended(susp));
    // ****************************************
    // bus tasks and checks
    // ****************************************
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'b111};
        for (n = 0; n < 200; n++) begin
            @(posedge MCLK);
            if (AWREADY && AWVALID) AWVALID <= 1'b0;
            if (WREADY && WVALID) WVALID <= 1'b0;
            if (BVALID && BREADY) begin
                rsp = BRESP;
                BREADY <= 1'b0;
                break;
            end
        end
        if (n == 200) begin failures++; stop_test(); end
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge MCLK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
        for (n = 0; n < 200; n++) begin
            @(posedge MCLK);
            if (ARREADY && ARVALID) ARVALID <= 1'b0;
            if (RVALID && RREADY) begin
                rv = RDATA;
                rsp = RRESP;
                RREADY <= 1'b0;
                break;
            end
        end
        if (n == 200) begin failures++; stop_test(); end
    endtask
    task automatic cmd(input logic [3:0] op, input logic [31:0] ad);
        int n;
        axw(escs_pkg::REG_ADDR, ad);
        axw(escs_pkg::REG_CMD, {28'h0, op});
        for (n = 0; n < 100; n++) begin
            axr(escs_pkg::REG_STATUS);
            @(posedge MCLK);
            if (rv[escs_pkg::ST_BUSY] === 1'b0) break;
        end
        if (n == 100) begin failures++; stop_test(); end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_suspend();
        cmd(escs_pkg::OP_CERASE, 32'h0);
        cmd(escs_pkg::OP_SUSPEND, 32'h0);
        check(rv & 32'hF, 32'h2);
        axw(escs_pkg::REG_STATUS, 32'h2);
        cmd(escs_pkg::OP_SERASE, 32'h23000);
        cmd(escs_pkg::OP_SUSPEND, 32'h0);
        check(rv & 32'hF, 32'hC);
        check({31'h0, susp}, 32'h1);
    endtask
    task automatic t_reads();
        cmd(escs_pkg::OP_READ, 32'h23010);
        check(rv & 32'h2, 32'h2);
        axw(escs_pkg::REG_STATUS, 32'h2);
        cmd(escs_pkg::OP_READ, 32'h45010);
        axr(escs_pkg::REG_RDATA);
        check(rv, 32'h0000_0A4A);
    endtask
    task automatic t_ident();
        cmd(escs_pkg::OP_LOCKID, 32'h0);
        axr(escs_pkg::REG_RDATA);
        check(rv, 32'h0089);
        cmd(escs_pkg::OP_PROTVFY, 32'h23000);
        axr(escs_pkg::REG_RDATA);
        check(rv, 32'h0001);
        cmd(escs_pkg::OP_RESET, 32'h0);
        check({31'h0, susp}, 32'h1);
    endtask
    task automatic t_modes();
        cmd(escs_pkg::OP_PROG, 32'h45020);
        check(rv, 32'hC);
        cmd(escs_pkg::OP_SECENTER, 32'h0);
        check(rv, 32'hC);
        cmd(escs_pkg::OP_BYPENTER, 32'h0);
        cmd(escs_pkg::OP_BYPPROG, 32'h45030);
        check(rv, 32'hC);
    endtask
    task automatic t_resume();
        cmd(escs_pkg::OP_RESUME, 32'h0);
        check({rv[3:0], 3'h0, susp}, 32'h40);
        cmd(escs_pkg::OP_RESUME, 32'h0);
        check(rv & 32'h2, 32'h2);
        axw(escs_pkg::REG_STATUS, 32'h2);
        cmd(escs_pkg::OP_SUSPEND, 32'h0);
        check({31'h0, susp}, 32'h1);
        axr(8'h40);
        check({30'h0, rsp}, 32'h2);
        axw(escs_pkg::REG_CLEAR, 32'h1);
        axr(escs_pkg::REG_STATUS);
        check(rv, 32'h0);
    endtask
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    initial begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
        repeat (10) @(posedge MCLK);
        RST_N <= 1'b1;
        axr(escs_pkg::REG_STATUS);
        check(rv, 32'h0);
        t_suspend();
        t_reads();
        t_ident();
        t_modes();
        t_resume();
        stop_test();
    end
endmodule
`default_nettype wire
